// file: logic/kgs_config_bank.sv
// keyboard glue, slow-clock wake and security key configuration bank
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps

module kgs_config_bank (
    // clock and standby power-on reset
    input wire logic core_clk,
    input wire logic rst,
    // main supply power-on or bus reset, asynchronous level
    input wire logic main_rst_in,
    // register port
    input wire kgs_pkg::kgs_bus_req_t bus_req,
    output logic [7:0] rd_data,
    // mouse and keyboard pins
    input wire kgs_pkg::kgs_line_pair_t mouse_pins,
    input wire kgs_pkg::kgs_line_pair_t keyboard_pins,
    // lines toward the keyboard core and the wake logic
    output kgs_pkg::kgs_line_pair_t core_mouse_lines,
    output kgs_pkg::kgs_line_pair_t core_keyboard_lines,
    output logic wake_mouse_data_line,
    output logic wake_keyboard_data_line,
    // keyboard core interrupts and port-one bit-two
    input wire logic core_mouse_irq,
    input wire logic core_keyboard_irq,
    input wire logic mouse_irq_latch_clear,
    input wire logic keyboard_irq_latch_clear,
    input wire logic core_port_one_bit_two,
    output logic mouse_irq,
    output logic keyboard_irq,
    output logic kbc_port_one_bit_two,
    output logic fast_gate_port_en,
    // slow clock and wake logic control
    output logic slow_clock_absent,
    output logic key_wake_clk_en,
    output logic click_wake_clk_en,
    // floppy routing
    output logic [1:0] floppy_on_parallel_mode,
    output logic drive0_on_parallel_port,
    output logic drive1_on_parallel_port,
    // serial port two
    output logic second_tx_float_force,
    // security key block access
    input wire logic key_rd_en,
    input wire logic [7:0] key_store_rdata,
    output logic [7:0] key_rdata,
    input wire logic key_wr_en,
    output logic key_store_wr_en
);
    import kgs_pkg::*;

    // ------------------------------------------------------------
    // main reset synchroniser
    // ------------------------------------------------------------
    // bus reset comes from the main supply side, so it passes two flops
    // comes up asserted so main-domain bits stay cleared until sync settles
    logic main_rst_meta_reg;
    logic main_rst_sync_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            main_rst_meta_reg <= 1'b1;
            main_rst_sync_reg <= 1'b1;
        end else begin
            main_rst_meta_reg <= main_rst_in;
            main_rst_sync_reg <= main_rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_raw;
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;

    assign pin_raw = {mouse_pins.clk, mouse_pins.data, keyboard_pins.clk, keyboard_pins.data};

    // lines idle high, so reset to the released level
    // no false edge toward the core as reset lets go
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= 4'hF;
            pin_sync_reg <= 4'hF;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic hit_tx_mode;
    logic hit_glue;
    logic hit_slow;
    logic hit_floppy;
    logic hit_vault;

    assign hit_tx_mode = (bus_req.ldn == LDN_SERIAL_TWO) && (bus_req.index == IDX_SERIAL_TWO_MODE);
    assign hit_glue = (bus_req.ldn == LDN_KEYBOARD) && (bus_req.index == IDX_KEYBOARD_GLUE);
    assign hit_slow = (bus_req.ldn == LDN_RUNTIME) && (bus_req.index == IDX_SLOW_CLOCK);
    assign hit_floppy = (bus_req.ldn == LDN_RUNTIME) && (bus_req.index == IDX_FLOPPY_MODE);
    assign hit_vault = (bus_req.ldn == LDN_RUNTIME) && (bus_req.index == IDX_KEY_VAULT);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic tx_float_reg;
    logic tx_float_next;
    logic [7:0] glue_reg;
    logic [7:0] glue_next;
    logic [7:0] slow_reg;
    logic [7:0] slow_next;
    logic [7:0] floppy_reg;
    logic [7:0] floppy_next;
    logic [7:0] vault_reg;
    logic [7:0] vault_next;

    always_comb begin
        tx_float_next = tx_float_reg;
        glue_next = glue_reg;
        slow_next = slow_reg;
        floppy_next = floppy_reg;
        vault_next = vault_reg;
        if (bus_req.wr && hit_tx_mode) begin
            tx_float_next = bus_req.wdata[TX_FLOAT_BIT];
        end
        if (bus_req.wr && hit_glue) begin
            glue_next = bus_req.wdata;
        end
        if (bus_req.wr && hit_slow) begin
            slow_next = bus_req.wdata & SLOW_CLOCK_MASK;
        end
        // floppy reserved bits dropped on write
        if (bus_req.wr && hit_floppy) begin
            floppy_next = bus_req.wdata & FLOPPY_MODE_MASK;
        end
        // only a reset can reopen a locked control register
        // lock freezes register
        if (bus_req.wr && hit_vault && !vault_reg[VAULT_LOCK_BIT]) begin
            vault_next = bus_req.wdata & KEY_VAULT_MASK;
        end
        // placed last so a reset cycle beats a write in the same cycle
        // main reset spares isolation bits
        if (main_rst_sync_reg) begin
            glue_next = (glue_reg & GLUE_STANDBY_MASK) | (GLUE_RESET & ~GLUE_STANDBY_MASK);
            floppy_next = FLOPPY_MODE_RESET;
            vault_next = KEY_VAULT_RESET;
        end
    end

    // slow-clock register cleared by standby reset only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_float_reg <= 1'b0;
            glue_reg <= GLUE_RESET;
            slow_reg <= SLOW_CLOCK_RESET;
            floppy_reg <= FLOPPY_MODE_RESET;
            vault_reg <= KEY_VAULT_RESET;
        end else begin
            tx_float_reg <= tx_float_next;
            glue_reg <= glue_next;
            slow_reg <= slow_next;
            floppy_reg <= floppy_next;
            vault_reg <= vault_next;
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    // idle and unmapped cycles read zero, so read buses can be or-ed upstream
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    always_comb begin
        rd_data_next = READ_ZERO;
        if (bus_req.rd) begin
            if (hit_tx_mode) begin
                rd_data_next[TX_FLOAT_BIT] = tx_float_reg;
            end else if (hit_glue) begin
                rd_data_next = glue_reg;
            end else if (hit_slow) begin
                rd_data_next = slow_reg;
            end else if (hit_floppy) begin
                rd_data_next = floppy_reg;
            end else if (hit_vault) begin
                rd_data_next = vault_reg;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= READ_ZERO;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;

    // ------------------------------------------------------------
    // interrupt latches
    // ------------------------------------------------------------
    logic mouse_latch_reg;
    logic mouse_latch_next;
    logic keyboard_latch_reg;
    logic keyboard_latch_next;
    logic mouse_irq_reg;
    logic mouse_irq_next;
    logic keyboard_irq_reg;
    logic keyboard_irq_next;

    // a request in the clearing cycle keeps the latch set
    // so an edge from the core is never lost to a late software clear
    always_comb begin
        mouse_latch_next = core_mouse_irq | (mouse_latch_reg & ~mouse_irq_latch_clear);
        keyboard_latch_next = core_keyboard_irq | (keyboard_latch_reg & ~keyboard_irq_latch_clear);
        if (glue_reg[GLUE_MOUSE_IRQ_LATCH_SELECT_BIT]) begin
            mouse_irq_next = mouse_latch_next;
        end else begin
            mouse_irq_next = core_mouse_irq & mouse_latch_next;
        end
        if (glue_reg[GLUE_KEYBOARD_IRQ_LATCH_SELECT_BIT]) begin
            keyboard_irq_next = keyboard_latch_next;
        end else begin
            keyboard_irq_next = core_keyboard_irq & keyboard_latch_next;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mouse_latch_reg <= 1'b0;
            keyboard_latch_reg <= 1'b0;
            mouse_irq_reg <= 1'b0;
            keyboard_irq_reg <= 1'b0;
        end else begin
            mouse_latch_reg <= mouse_latch_next;
            keyboard_latch_reg <= keyboard_latch_next;
            mouse_irq_reg <= mouse_irq_next;
            keyboard_irq_reg <= keyboard_irq_next;
        end
    end

    assign mouse_irq = mouse_irq_reg;
    assign keyboard_irq = keyboard_irq_reg;

    // ------------------------------------------------------------
    // keyboard core glue outputs
    // ------------------------------------------------------------
    kgs_line_pair_t core_mouse_next;
    kgs_line_pair_t core_keyboard_next;
    kgs_line_pair_t core_mouse_reg;
    kgs_line_pair_t core_keyboard_reg;
    logic wake_mouse_reg;
    logic wake_keyboard_reg;
    logic port_bit_reg;
    logic port_bit_next;

    always_comb begin
        if (glue_reg[GLUE_MOUSE_ISO_BIT]) begin
            core_mouse_next = '{clk: 1'b1, data: 1'b1};
        end else begin
            core_mouse_next = '{clk: pin_sync_reg[3], data: pin_sync_reg[2]};
        end
        if (glue_reg[GLUE_KBD_ISO_BIT]) begin
            core_keyboard_next = '{clk: 1'b1, data: 1'b1};
        end else begin
            core_keyboard_next = '{clk: pin_sync_reg[1], data: pin_sync_reg[0]};
        end
        // registered so a polarity change cannot glitch the downstream line
        // polarity of port-one bit-two
        if (glue_reg[GLUE_POLARITY_BIT]) begin
            port_bit_next = core_port_one_bit_two;
        end else begin
            port_bit_next = ~core_port_one_bit_two;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            core_mouse_reg <= '{clk: 1'b1, data: 1'b1};
            core_keyboard_reg <= '{clk: 1'b1, data: 1'b1};
            wake_mouse_reg <= 1'b1;
            wake_keyboard_reg <= 1'b1;
            port_bit_reg <= 1'b1;
        end else begin
            core_mouse_reg <= core_mouse_next;
            core_keyboard_reg <= core_keyboard_next;
            wake_mouse_reg <= pin_sync_reg[2];
            wake_keyboard_reg <= pin_sync_reg[0];
            port_bit_reg <= port_bit_next;
        end
    end

    assign core_mouse_lines = core_mouse_reg;
    assign core_keyboard_lines = core_keyboard_reg;
    assign wake_mouse_data_line = wake_mouse_reg;
    assign wake_keyboard_data_line = wake_keyboard_reg;
    assign kbc_port_one_bit_two = port_bit_reg;
    assign fast_gate_port_en = glue_reg[GLUE_FAST_GATE_BIT];

    // ------------------------------------------------------------
    // slow clock, floppy routing and serial outputs
    // ------------------------------------------------------------
    // absence flag straight from storage
    assign slow_clock_absent = slow_reg[SLOW_ABSENT_BIT];
    // stored bits are offs while the gate wants an enable, hence the inversion
    // enable for key wake clock gate
    assign key_wake_clk_en = ~slow_reg[SLOW_KEY_OFF_BIT];
    // enable for click wake clock gate
    assign click_wake_clk_en = ~slow_reg[SLOW_CLICK_OFF_BIT];
    assign second_tx_float_force = tx_float_reg;

    assign floppy_on_parallel_mode = floppy_reg[1:0];

    // falling back to normal keeps a stray reserved write from moving drives
    // drive routing decode, reserved code acts as normal
    always_comb begin
        case (floppy_reg[1:0])
            FLOPPY_SPLIT: begin
                drive0_on_parallel_port = 1'b0;
                drive1_on_parallel_port = 1'b1;
            end
            FLOPPY_BOTH_PP: begin
                drive0_on_parallel_port = 1'b1;
                drive1_on_parallel_port = 1'b1;
            end
            default: begin
                drive0_on_parallel_port = 1'b0;
                drive1_on_parallel_port = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // security key block gating
    // ------------------------------------------------------------
    logic [7:0] key_rdata_reg;
    logic [7:0] key_rdata_next;

    always_comb begin
        key_rdata_next = key_rdata_reg;
        // lock sampled with the request, so a byte read after locking is zero
        // read-lock forces zero
        if (key_rd_en) begin
            key_rdata_next = vault_reg[VAULT_READ_LOCK_BIT] ? READ_ZERO : key_store_rdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            key_rdata_reg <= READ_ZERO;
        end else begin
            key_rdata_reg <= key_rdata_next;
        end
    end

    assign key_rdata = key_rdata_reg;
    // combinational so a discarded write never reaches the store for a cycle
    // write-lock discards writes
    assign key_store_wr_en = key_wr_en & ~vault_reg[VAULT_WRITE_LOCK_BIT];

endmodule

// file: logic/kgs_pkg.sv
// constants and carriers for the keyboard glue and security configuration bank

package kgs_pkg;

    // ------------------------------------------------------------
    // logical device numbers and register indices
    // ------------------------------------------------------------
    localparam logic [7:0] LDN_SERIAL_TWO = 8'h05;
    localparam logic [7:0] LDN_KEYBOARD = 8'h07;
    localparam logic [7:0] LDN_RUNTIME = 8'h0A;

    localparam logic [7:0] IDX_SERIAL_TWO_MODE = 8'hF0;
    localparam logic [7:0] IDX_KEYBOARD_GLUE = 8'hF0;
    localparam logic [7:0] IDX_SLOW_CLOCK = 8'hF0;
    localparam logic [7:0] IDX_FLOPPY_MODE = 8'hF1;
    localparam logic [7:0] IDX_KEY_VAULT = 8'hF2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TX_FLOAT_BIT = 5;
    localparam int GLUE_POLARITY_BIT = 7;
    localparam int GLUE_MOUSE_ISO_BIT = 6;
    localparam int GLUE_KBD_ISO_BIT = 5;
    localparam int GLUE_MOUSE_IRQ_LATCH_SELECT_BIT = 4;
    localparam int GLUE_KEYBOARD_IRQ_LATCH_SELECT_BIT = 3;
    localparam int GLUE_FAST_GATE_BIT = 2;
    localparam int SLOW_ABSENT_BIT = 0;
    localparam int SLOW_KEY_OFF_BIT = 1;
    localparam int SLOW_CLICK_OFF_BIT = 3;
    localparam int VAULT_LOCK_BIT = 0;
    localparam int VAULT_READ_LOCK_BIT = 1;
    localparam int VAULT_WRITE_LOCK_BIT = 2;

    // ------------------------------------------------------------
    // writable and standby-kept masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GLUE_STANDBY_MASK = 8'h60;
    localparam logic [7:0] SLOW_CLOCK_MASK = 8'h0B;
    localparam logic [7:0] FLOPPY_MODE_MASK = 8'h03;
    localparam logic [7:0] KEY_VAULT_MASK = 8'h07;
    localparam logic [7:0] GLUE_RESET = 8'h00;
    localparam logic [7:0] SLOW_CLOCK_RESET = 8'h00;
    localparam logic [7:0] FLOPPY_MODE_RESET = 8'h00;
    localparam logic [7:0] KEY_VAULT_RESET = 8'h04;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // floppy routing modes
    localparam logic [1:0] FLOPPY_NORMAL = 2'h0;
    localparam logic [1:0] FLOPPY_SPLIT = 2'h1;
    localparam logic [1:0] FLOPPY_BOTH_PP = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ldn;
        logic [7:0] index;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } kgs_bus_req_t;

    typedef struct packed {
        logic clk;
        logic data;
    } kgs_line_pair_t;

endpackage

// file: verification/kgs_config_monitor.sv
// port assertions for the keyboard glue and security configuration bank
`timescale 1ns/10ps

module kgs_config_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // watched ports
    input wire kgs_pkg::kgs_bus_req_t bus_req,
    input wire logic [7:0] rd_data,
    input wire kgs_pkg::kgs_line_pair_t mouse_pins,
    input wire logic wake_mouse_data_line,
    input wire logic core_mouse_irq,
    input wire logic mouse_irq,
    input wire logic slow_clock_absent,
    input wire logic key_wake_clk_en,
    input wire logic click_wake_clk_en,
    input wire logic [1:0] floppy_on_parallel_mode,
    input wire logic drive0_on_parallel_port,
    input wire logic drive1_on_parallel_port,
    input wire logic second_tx_float_force,
    input wire logic key_rd_en,
    input wire logic [7:0] key_store_rdata,
    input wire logic [7:0] key_rdata,
    input wire logic key_wr_en,
    input wire logic key_store_wr_en
);
    import kgs_pkg::*;
    // ----------------------------------------
    // cycles since reset, so deep history is never pre-reset
    // ----------------------------------------
    logic [2:0] up_reg;
    logic [2:0] up_next;
    always_comb begin
        up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            up_reg <= 3'h0;
        end else begin
            up_reg <= up_next;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_rd_data_idle: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
        else $error("read data not zero outside the read answer cycle");
    a_key_hold: assert property (!$past(key_rd_en) |-> $stable(key_rdata))
        else $error("key read data moved without a key read");
    a_key_source: assert property ($past(key_rd_en) |->
        (key_rdata == $past(key_store_rdata)) || (key_rdata == 8'h00))
        else $error("key read data neither stored byte nor zero");
    a_store_gate: assert property (key_store_wr_en |-> key_wr_en)
        else $error("key store write without a key write");
    a_split_decode: assert property (floppy_on_parallel_mode == 2'h1 |->
        !drive0_on_parallel_port && drive1_on_parallel_port)
        else $error("mode one drive routing wrong");
    a_both_decode: assert property (floppy_on_parallel_mode == 2'h2 |->
        drive0_on_parallel_port && drive1_on_parallel_port)
        else $error("mode two drive routing wrong");
    a_normal_decode: assert property (floppy_on_parallel_mode == 2'h0 |->
        !drive0_on_parallel_port && !drive1_on_parallel_port)
        else $error("normal mode drive routing wrong");
    a_irq_follow: assert property ($past(core_mouse_irq) |-> mouse_irq)
        else $error("mouse interrupt missed a core request");
    a_wake_path: assert property (up_reg == 3'h7 |->
        wake_mouse_data_line == $past(mouse_pins.data, 3))
        else $error("wake data line does not follow the pin");
    a_slow_write: assert property (($changed(slow_clock_absent) || $changed(key_wake_clk_en)
        || $changed(click_wake_clk_en)) |-> $past(bus_req.wr))
        else $error("slow clock controls changed without a write");
    a_tx_write: assert property ($changed(second_tx_float_force) |-> $past(bus_req.wr))
        else $error("float force changed without a write");
endmodule

bind kgs_config_bank kgs_config_monitor u_mon (.core_clk(core_clk), .rst(rst),
    .bus_req(bus_req), .rd_data(rd_data), .mouse_pins(mouse_pins),
    .wake_mouse_data_line(wake_mouse_data_line), .core_mouse_irq(core_mouse_irq),
    .mouse_irq(mouse_irq), .slow_clock_absent(slow_clock_absent),
    .key_wake_clk_en(key_wake_clk_en), .click_wake_clk_en(click_wake_clk_en),
    .floppy_on_parallel_mode(floppy_on_parallel_mode),
    .drive0_on_parallel_port(drive0_on_parallel_port),
    .drive1_on_parallel_port(drive1_on_parallel_port),
    .second_tx_float_force(second_tx_float_force), .key_rd_en(key_rd_en),
    .key_store_rdata(key_store_rdata), .key_rdata(key_rdata), .key_wr_en(key_wr_en),
    .key_store_wr_en(key_store_wr_en));

// file: verification/kgs_testbench.sv
// self-checking bench for the configuration bank against an integer model
`timescale 1ns/10ps

module testbench;
    import kgs_pkg::*;
    logic core_clk, rst, main_rst_in;
    kgs_bus_req_t bus_req;
    logic [7:0] rd_data, key_store_rdata, key_rdata;
    kgs_line_pair_t mouse_pins, keyboard_pins, core_mouse_lines, core_keyboard_lines;
    logic wake_m, wake_k, core_m_irq, core_k_irq, m_clr, k_clr, core_p12;
    logic mouse_irq, keyboard_irq, kbc_p12, fast_gate, slow_abs, key_clk, click_clk;
    logic [1:0] fmode;
    logic drv0, drv1, txf, key_rd_en, key_wr_en, key_store_wr_en;
    int n_fail = 0, checked = 0, n, seed_v;
    int mg, ms, mf, mv, mt;
    logic [15:0] a;
    logic [7:0] d;
    logic [15:0] amap [6] = '{16'h05F0, 16'h07F0, 16'h0AF0, 16'h0AF1, 16'h0AF2, 16'h0AF3};

    kgs_config_bank u_dut (.core_clk(core_clk), .rst(rst), .main_rst_in(main_rst_in),
        .bus_req(bus_req), .rd_data(rd_data), .mouse_pins(mouse_pins),
        .keyboard_pins(keyboard_pins), .core_mouse_lines(core_mouse_lines),
        .core_keyboard_lines(core_keyboard_lines), .wake_mouse_data_line(wake_m),
        .wake_keyboard_data_line(wake_k), .core_mouse_irq(core_m_irq),
        .core_keyboard_irq(core_k_irq), .mouse_irq_latch_clear(m_clr),
        .keyboard_irq_latch_clear(k_clr), .core_port_one_bit_two(core_p12),
        .mouse_irq(mouse_irq), .keyboard_irq(keyboard_irq), .kbc_port_one_bit_two(kbc_p12),
        .fast_gate_port_en(fast_gate), .slow_clock_absent(slow_abs),
        .key_wake_clk_en(key_clk), .click_wake_clk_en(click_clk),
        .floppy_on_parallel_mode(fmode), .drive0_on_parallel_port(drv0),
        .drive1_on_parallel_port(drv1), .second_tx_float_force(txf),
        .key_rd_en(key_rd_en), .key_store_rdata(key_store_rdata), .key_rdata(key_rdata),
        .key_wr_en(key_wr_en), .key_store_wr_en(key_store_wr_en));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic final_report;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] exp_rd(input logic [15:0] adr);
        case (adr)
            16'h05F0: return 8'(mt << 5);
            16'h07F0: return 8'(mg);
            16'h0AF0: return 8'(ms);
            16'h0AF1: return 8'(mf);
            16'h0AF2: return 8'(mv);
            default: return 8'h00;
        endcase
    endfunction

    task automatic wr(input logic [15:0] adr, input logic [7:0] dat);
        @(posedge core_clk);
        bus_req <= '{ldn: adr[15:8], index: adr[7:0], wdata: dat, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        // slow and vault keep only their defined bits; a locked vault ignores writes
        case (adr)
            16'h05F0: mt = dat[5];
            16'h07F0: mg = dat;
            16'h0AF0: ms = dat & 8'h0B;
            16'h0AF1: mf = dat & 8'h03;
            16'h0AF2: if (mv[0] == 1'b0) mv = dat & 8'h07;
            default: ;
        endcase
    endtask

    task automatic rd(input logic [15:0] adr);
        @(posedge core_clk);
        bus_req <= '{ldn: adr[15:8], index: adr[7:0], wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        @(negedge core_clk);
        chk(rd_data, exp_rd(adr));
    endtask

    task automatic rd_all;
        for (int k = 0; k < 6; k++) rd(amap[k]);
    endtask

    task automatic chk_outs;
        @(negedge core_clk);
        chk({fast_gate, slow_abs, key_clk, click_clk, txf, fmode, 1'b0},
            {mg[2], ms[0], ~ms[1], ~ms[3], mt[0], 2'(mf), 1'b0});
    endtask

    task automatic key_op(input logic [7:0] dat);
        @(posedge core_clk);
        key_rd_en <= 1'b1;
        key_wr_en <= 1'b1;
        key_store_rdata <= dat;
        @(negedge core_clk);
        chk({7'h00, key_store_wr_en}, {7'h00, ~mv[2]});
        @(posedge core_clk);
        key_rd_en <= 1'b0;
        key_wr_en <= 1'b0;
        key_store_rdata <= ~dat;
        @(negedge core_clk);
        chk(key_rdata, mv[1] ? 8'h00 : dat);
    endtask

    initial begin
        #200000;
        n_fail++;
        final_report;
    end

    initial begin
        seed_v = $urandom(32'h82955d6b);
        rst = 1'b1;
        main_rst_in = 1'b0;
        bus_req = '0;
        mouse_pins = 2'h3;
        keyboard_pins = 2'h3;
        {core_m_irq, core_k_irq, m_clr, k_clr, core_p12} = 5'h00;
        {key_rd_en, key_wr_en} = 2'h0;
        key_store_rdata = 8'h00;
        {mg, ms, mf, mt} = {32'd0, 32'd0, 32'd0, 32'd0};
        mv = 4;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        rd_all;
        for (n = 0; n < 24; n++) begin
            a = amap[$urandom % 6];
            d = 8'($urandom);
            if (a == 16'h0AF2) d[0] = 1'b0;
            wr(a, d);
            rd(a);
            chk_outs;
        end
        for (n = 0; n < 4; n++) begin
            wr(16'h0AF1, 8'(n));
            @(negedge core_clk);
            chk({6'h00, drv0, drv1}, {6'h00, n == 2, n == 1 || n == 2});
        end
        // polarity on n[0], mouse isolation on n[1], keyboard isolation on n[0]
        for (n = 0; n < 4; n++) begin
            wr(16'h07F0, {n[0], n[1], n[0], 5'h00});
            @(posedge core_clk);
            mouse_pins <= 2'($urandom);
            keyboard_pins <= 2'($urandom);
            core_p12 <= n[1];
            repeat (4) @(posedge core_clk);
            @(negedge core_clk);
            chk({1'b0, core_mouse_lines, core_keyboard_lines, wake_m, wake_k, kbc_p12},
                {1'b0, n[1] ? 2'h3 : mouse_pins, n[0] ? 2'h3 : keyboard_pins,
                mouse_pins.data, keyboard_pins.data, ~(n[0] ^ n[1])});
        end
        for (n = 0; n < 2; n++) begin
            wr(16'h07F0, n ? 8'h18 : 8'h00);
            @(posedge core_clk);
            {core_m_irq, core_k_irq} <= 2'h3;
            @(posedge core_clk);
            {core_m_irq, core_k_irq} <= 2'h0;
            @(negedge core_clk);
            chk({6'h00, mouse_irq, keyboard_irq}, 8'h03);
            @(posedge core_clk);
            {m_clr, k_clr} <= 2'h3;
            @(negedge core_clk);
            chk({6'h00, mouse_irq, keyboard_irq}, n ? 8'h03 : 8'h00);
            @(posedge core_clk);
            {m_clr, k_clr} <= 2'h0;
            @(negedge core_clk);
            chk({6'h00, mouse_irq, keyboard_irq}, 8'h00);
        end
        for (n = 0; n < 4; n++) begin
            wr(16'h0AF2, 8'(n << 1));
            key_op(8'($urandom));
        end
        wr(16'h0AF2, 8'h01);
        wr(16'h0AF2, 8'h06);
        rd(16'h0AF2);
        for (n = 0; n < 4; n++) wr(amap[n], 8'hFF);
        // main supply reset keeps isolation, slow clock and float force
        @(posedge core_clk);
        main_rst_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        main_rst_in <= 1'b0;
        repeat (4) @(posedge core_clk);
        mg = mg & 8'h60;
        mf = 0;
        mv = 4;
        rd_all;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        {mg, ms, mf, mt} = {32'd0, 32'd0, 32'd0, 32'd0};
        mv = 4;
        repeat (5) @(posedge core_clk);
        rd_all;
        chk_outs;
        final_report;
    end
endmodule
